//--- core/lpc_pkg.sv
// lpc_pkg: constants, command codes and carrier types of the lcd pointer and mode decoder
package lpc_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0]  LPC_OFS_DATA       = 8'h00;  // w: push parameter byte, r: last two
  localparam logic [7:0]  LPC_OFS_CMD        = 8'h04;  // w: execute command byte
  localparam logic [7:0]  LPC_OFS_CURSOR     = 8'h08;  // r: {row[12:8], col[6:0]}
  localparam logic [7:0]  LPC_OFS_OFFSET     = 8'h0C;  // r: glyph ram base field
  localparam logic [7:0]  LPC_OFS_ADDR_PTR   = 8'h10;  // r: display memory access pointer
  localparam logic [7:0]  LPC_OFS_TEXT_BASE  = 8'h14;  // r: text base address
  localparam logic [7:0]  LPC_OFS_TEXT_PITCH = 8'h18;  // r: text row pitch
  localparam logic [7:0]  LPC_OFS_GFX_BASE   = 8'h1C;  // r: graphic base address
  localparam logic [7:0]  LPC_OFS_GFX_PITCH  = 8'h20;  // r: graphic row pitch
  localparam logic [7:0]  LPC_OFS_MODE       = 8'h24;  // r: {glyph_ext[4], combine[3:0]}
  localparam logic [7:0]  LPC_OFS_STATUS     = 8'h28;  // r: {dual[8], hw cols[7:0]}

  // command codes
  localparam logic [7:0]  LPC_CMD_CURSOR     = 8'h21;
  localparam logic [7:0]  LPC_CMD_OFFSET     = 8'h22;
  localparam logic [7:0]  LPC_CMD_ADDR_PTR   = 8'h24;
  localparam logic [7:0]  LPC_CMD_TEXT_BASE  = 8'h40;
  localparam logic [7:0]  LPC_CMD_TEXT_PITCH = 8'h41;
  localparam logic [7:0]  LPC_CMD_GFX_BASE   = 8'h42;
  localparam logic [7:0]  LPC_CMD_GFX_PITCH  = 8'h43;
  localparam logic [3:0]  LPC_CMD_MODE_HI    = 4'h8;   // upper nibble of the mode command

  // combine field codes in the mode command
  localparam logic [2:0]  LPC_MODE_OR        = 3'h0;
  localparam logic [2:0]  LPC_MODE_XOR       = 3'h1;
  localparam logic [2:0]  LPC_MODE_AND       = 3'h3;
  localparam logic [2:0]  LPC_MODE_ATTR      = 3'h4;

  // glyph codes below this come from the built-in rom in internal mode
  localparam logic [7:0]  LPC_ROM_CODE_LIMIT = 8'h80;

  // attribute low-three-bit patterns
  localparam logic [2:0]  LPC_ATTR_NORMAL    = 3'h0;
  localparam logic [2:0]  LPC_ATTR_REVERSE   = 3'h5;
  localparam logic [2:0]  LPC_ATTR_INHIBIT   = 3'h3;
  localparam logic [2:0]  LPC_ATTR_BOLD      = 3'h7;

  // hardware column count by {column_strap_a, column_strap_b}
  localparam logic [7:0]  LPC_COLS_00        = 8'h28;
  localparam logic [7:0]  LPC_COLS_01        = 8'h40;
  localparam logic [7:0]  LPC_COLS_10        = 8'h50;
  localparam logic [7:0]  LPC_COLS_11        = 8'h20;

  // reset values and bus response codes
  localparam logic [15:0] LPC_RST_ADDR       = 16'h0000;
  localparam logic [7:0]  LPC_RST_PITCH      = 8'h00;
  localparam logic [1:0]  LPC_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  LPC_RESP_SLVERR    = 2'h2;

  // combine mode, one-hot
  typedef enum logic [3:0]
  {
    LPC_CMB_OR   = 4'b0001,
    LPC_CMB_XOR  = 4'b0010,
    LPC_CMB_AND  = 4'b0100,
    LPC_CMB_ATTR = 4'b1000
  } lpc_combine_t;

  // scan address request and answer
  typedef struct packed {
    logic       valid;    // request strobe
    logic       graphic;  // 1: graphic/attribute area, 0: text area
    logic [7:0] row;      // zero-based row index
    logic [6:0] col;      // column within the row
  } lpc_scan_req_t;

  typedef struct packed {
    logic        valid;    // answer strobe
    logic        is_attr;  // graphic fetch is an attribute byte
    logic [15:0] addr;     // display memory address
  } lpc_scan_rsp_t;

  // glyph request and answer
  typedef struct packed {
    logic       valid;
    logic [7:0] code;      // character code
    logic [2:0] line;      // glyph row 0..7
  } lpc_glyph_req_t;

  typedef struct packed {
    logic        valid;
    logic        from_rom; // 1: built-in rom, 0: glyph ram area
    logic [15:0] addr;     // glyph ram address
  } lpc_glyph_rsp_t;

  // decoded attribute
  typedef struct packed {
    logic valid;
    logic reverse;
    logic inhibit;
    logic bold;
    logic blink;
  } lpc_attr_t;

  // strap pins after synchronisation
  typedef struct packed {
    logic col_a;
    logic col_b;
    logic dual;
  } lpc_strap_t;

endpackage

//--- core/lpc_core.sv
// lpc_core: command decoder for cursor, pointers, control words, mode and attributes
//
// What this block does
// [R01] command 21h loads cursor column and row
// [R02] only cursor command changes the cursor
// [R03] keep seven column bits, five row bits
// [R04] dual scan: rows 10h-1Fh are lower half
// [R05] command 22h loads offset from first byte
// [R06] glyph address is offset, code, glyph row
// [R07] internal mode: codes below 80h from rom
// [R08] external mode: all codes from glyph ram
// [R09] command 24h loads access pointer low-high
// [R10] command 40h stores text base low-high
// [R11] text row starts base plus row times pitch
// [R12] command 42h stores graphic base low-high
// [R13] graphic row starts base plus row times pitch
// [R14] command 41h sets text pitch, host sends 00h
// [R15] command 43h sets graphic pitch, host sends 00h
// [R16] pitch equal columns gives contiguous graphic rows
// [R17] mode command: low bits combine, bit3 source
// [R18] mode held until next mode command
// [R19] attribute mode suppresses graphics, reads attributes
// [R20] host enables text and graphic for attributes
// [R21] decode attribute low nibble, d3 adds blink to listed patterns only
// [R22] host sends parameters before the command
// [R23] extra parameters: last one or two used
// [R24] host checks status before each transfer
// [R25] offset keeps five low bits only
// [R26] unlisted attribute patterns display as normal
`timescale 1ns/1ps
`default_nettype none

module lpc_core
(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // axi4-lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output var  logic                    s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output var  logic                    s_axi_wready,
  output var  logic [1:0]              s_axi_bresp,
  output var  logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output var  logic                    s_axi_arready,
  output var  logic [31:0]             s_axi_rdata,
  output var  logic [1:0]              s_axi_rresp,
  output var  logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // strap pins, asynchronous
  input  wire logic                    column_strap_a,
  input  wire logic                    column_strap_b,
  input  wire logic                    dual_scan_strap,
  // display scan side
  input  wire lpc_pkg::lpc_scan_req_t  scan_req,
  output var  lpc_pkg::lpc_scan_rsp_t  scan_rsp,
  input  wire lpc_pkg::lpc_glyph_req_t glyph_req,
  output var  lpc_pkg::lpc_glyph_rsp_t glyph_rsp,
  input  wire logic                    attr_valid,
  input  wire logic [7:0]              attr_byte,
  output var  lpc_pkg::lpc_attr_t      attr_out,
  output var  lpc_pkg::lpc_combine_t   combine_mode,
  output var  logic                    glyph_external,
  output var  logic                    graphic_suppress,
  output var  logic [6:0]              cursor_col,
  output var  logic [4:0]              cursor_row,
  output var  logic                    cursor_lower_half,
  output var  logic [15:0]             access_ptr,
  output var  logic [7:0]              hardware_column_count
);
  import lpc_pkg::*;

  // whole state of the block in one register
  typedef struct packed {
    logic           awready;
    logic           wready;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           arready;
    logic           rvalid;
    logic [1:0]     rresp;
    logic [31:0]    rdata;
    logic           aw_got;      // write address held
    logic           w_got;       // write data held
    logic [7:0]     awaddr;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    logic [7:0]     d1;          // older parameter byte
    logic [7:0]     d2;          // newer parameter byte
    logic [6:0]     cur_col;
    logic [4:0]     cur_row;
    logic           cur_lower;
    logic [4:0]     offset;
    logic [15:0]    adp;
    logic [15:0]    text_base;
    logic [7:0]     text_pitch;
    logic [15:0]    gfx_base;
    logic [7:0]     gfx_pitch;
    lpc_combine_t   combine;
    logic           glyph_ext;
    lpc_strap_t     strap_meta;  // first synchroniser stage, read only by strap
    lpc_strap_t     strap;       // second stage
    logic [7:0]     hw_cols;
    lpc_scan_rsp_t  scan;
    lpc_glyph_rsp_t glyph;
    lpc_attr_t      attr;
  } lpc_state_t;

  lpc_state_t st;                // registered state
  lpc_state_t next_st;           // next state
  logic       exec_cmd;          // command write completes this cycle
  logic       push_data;         // parameter write completes this cycle
  logic [7:0] cmd;               // command byte being executed

  // address decode shared by read and write paths
  function automatic logic lpc_mapped(input logic [7:0] a);
    lpc_mapped = (a[1:0] == 2'b00) && (a <= LPC_OFS_STATUS);
  endfunction

  // strap pair to visible column count
  function automatic logic [7:0] lpc_cols(input logic a, input logic b);
    unique case ({a, b})
      2'b00:   lpc_cols = LPC_COLS_00;
      2'b01:   lpc_cols = LPC_COLS_01;
      2'b10:   lpc_cols = LPC_COLS_10;
      default: lpc_cols = LPC_COLS_11;
    endcase
  endfunction

  // read mux; unmapped offsets read zero
  function automatic logic [31:0] lpc_read(input lpc_state_t s, input logic [7:0] a);
    unique case (a)
      LPC_OFS_DATA:       lpc_read = {16'h0000, s.d2, s.d1};
      LPC_OFS_CURSOR:     lpc_read = {19'h0_0000, s.cur_row, 1'b0, s.cur_col};
      LPC_OFS_OFFSET:     lpc_read = {27'h000_0000, s.offset};
      LPC_OFS_ADDR_PTR:   lpc_read = {16'h0000, s.adp};
      LPC_OFS_TEXT_BASE:  lpc_read = {16'h0000, s.text_base};
      LPC_OFS_TEXT_PITCH: lpc_read = {24'h00_0000, s.text_pitch};
      LPC_OFS_GFX_BASE:   lpc_read = {16'h0000, s.gfx_base};
      LPC_OFS_GFX_PITCH:  lpc_read = {24'h00_0000, s.gfx_pitch};
      LPC_OFS_MODE:       lpc_read = {27'h000_0000, s.glyph_ext, s.combine};
      LPC_OFS_STATUS:     lpc_read = {23'h00_0000, s.strap.dual, s.hw_cols};
      default:            lpc_read = 32'h0000_0000;
    endcase
  endfunction

  // next-state logic: bus slave, command decode, scan and glyph address generation
  always_comb
  begin
    next_st   = st;
    cmd       = st.wdata[7:0];
    exec_cmd  = 1'b0;
    push_data = 1'b0;

    // two-stage strap synchroniser; straps may move at any time
    next_st.strap_meta = '{col_a: column_strap_a, col_b: column_strap_b, dual: dual_scan_strap};
    next_st.strap      = st.strap_meta;
    next_st.hw_cols    = lpc_cols(st.strap.col_a, st.strap.col_b);

    // write address and data are taken independently, in either order
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_got  = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_got  = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
      next_st.wready = 1'b0;
    end

    // both halves held: perform the write and raise the response
    if (st.aw_got && st.w_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = lpc_mapped(st.awaddr) ? LPC_RESP_OKAY : LPC_RESP_SLVERR;
      // byte lane 0 carries every writable byte; other lanes are ignored
      if (st.wstrb[0])
      begin
        push_data = (st.awaddr == LPC_OFS_DATA);
        exec_cmd  = (st.awaddr == LPC_OFS_CMD);
      end
    end
    if (st.bvalid && s_axi_bready)
    begin
      // only one write in flight, so both channels reopen together
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // parameter stack: newest two bytes survive any surplus [R23]
    if (push_data)
    begin
      next_st.d1 = st.d2;
      next_st.d2 = cmd;
    end

    // command decode; host has stacked its operands beforehand [R22]
    if (exec_cmd)
    begin
      if (cmd == LPC_CMD_CURSOR)
      begin
        // only this path writes the cursor [R01] [R02]
        next_st.cur_col = st.d1[6:0];  // [R03]
        next_st.cur_row = st.d2[4:0];  // [R03]
      end
      else if (cmd == LPC_CMD_OFFSET)
        next_st.offset = st.d1[4:0];   // upper bits and d2 ignored [R05] [R25]
      else if (cmd == LPC_CMD_ADDR_PTR)
        next_st.adp = {st.d2, st.d1};  // [R09]
      else if (cmd == LPC_CMD_TEXT_BASE)
        next_st.text_base = {st.d2, st.d1};  // [R10]
      else if (cmd == LPC_CMD_TEXT_PITCH)
        next_st.text_pitch = st.d1;    // second byte is the host's 00h [R14]
      else if (cmd == LPC_CMD_GFX_BASE)
        next_st.gfx_base = {st.d2, st.d1};   // [R12]
      else if (cmd == LPC_CMD_GFX_PITCH)
        next_st.gfx_pitch = st.d1;     // [R15]
      else if (cmd[7:4] == LPC_CMD_MODE_HI)
      begin
        // mode fields change nowhere else [R17] [R18]
        next_st.glyph_ext = cmd[3];
        unique case (cmd[2:0])
          LPC_MODE_OR:   next_st.combine = LPC_CMB_OR;
          LPC_MODE_XOR:  next_st.combine = LPC_CMB_XOR;
          LPC_MODE_AND:  next_st.combine = LPC_CMB_AND;
          LPC_MODE_ATTR: next_st.combine = LPC_CMB_ATTR;
          default:       next_st.combine = LPC_CMB_OR;  // unlisted combine codes act as or
        endcase
      end
    end

    // lower-half flag only exists when the panel is strapped for dual scan [R04]
    next_st.cur_lower = st.strap.dual && st.cur_row[4];

    // read channel: answer one cycle after the address is taken
    if (s_axi_arvalid && st.arready)
    begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rdata   = lpc_read(st, s_axi_araddr);
      next_st.rresp   = lpc_mapped(s_axi_araddr) ? LPC_RESP_OKAY : LPC_RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end

    // scan address: base + row * pitch + column, registered one cycle [R11] [R13] [R16]
    next_st.scan.valid   = scan_req.valid;
    next_st.scan.is_attr = scan_req.graphic && (st.combine == LPC_CMB_ATTR);  // [R19]
    if (scan_req.graphic)
      next_st.scan.addr = st.gfx_base + ({8'h00, scan_req.row} * {8'h00, st.gfx_pitch})
                          + {9'h000, scan_req.col};
    else
      next_st.scan.addr = st.text_base + ({8'h00, scan_req.row} * {8'h00, st.text_pitch})
                          + {9'h000, scan_req.col};

    // glyph address and source choice [R06] [R07] [R08]
    next_st.glyph.valid    = glyph_req.valid;
    next_st.glyph.addr     = {st.offset, glyph_req.code, glyph_req.line};
    next_st.glyph.from_rom = !st.glyph_ext && (glyph_req.code < LPC_ROM_CODE_LIMIT);

    // attribute decode; upper nibble never looked at [R21] [R26]
    next_st.attr = '{valid: attr_valid, reverse: 1'b0, inhibit: 1'b0, bold: 1'b0, blink: 1'b0};
    unique case (attr_byte[2:0])
      LPC_ATTR_NORMAL:  next_st.attr.blink = attr_byte[3];
      LPC_ATTR_REVERSE:
      begin
        next_st.attr.reverse = 1'b1;
        next_st.attr.blink   = attr_byte[3];
      end
      LPC_ATTR_INHIBIT:
      begin
        next_st.attr.inhibit = 1'b1;
        next_st.attr.blink   = attr_byte[3];
      end
      LPC_ATTR_BOLD:
      begin
        next_st.attr.bold  = 1'b1;
        next_st.attr.blink = attr_byte[3];
      end
      default:          next_st.attr.blink = 1'b0;  // unlisted: plain normal
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st            <= '0;
      st.awready    <= 1'b1;
      st.wready     <= 1'b1;
      st.arready    <= 1'b1;
      st.adp        <= LPC_RST_ADDR;
      st.text_base  <= LPC_RST_ADDR;
      st.gfx_base   <= LPC_RST_ADDR;
      st.text_pitch <= LPC_RST_PITCH;
      st.gfx_pitch  <= LPC_RST_PITCH;
      st.combine    <= LPC_CMB_OR;
      st.hw_cols    <= LPC_COLS_00;
    end
    else
      st <= next_st;
  end

  // outputs straight from the state register
  assign s_axi_awready         = st.awready;
  assign s_axi_wready          = st.wready;
  assign s_axi_bresp           = st.bresp;
  assign s_axi_bvalid          = st.bvalid;
  assign s_axi_arready         = st.arready;
  assign s_axi_rdata           = st.rdata;
  assign s_axi_rresp           = st.rresp;
  assign s_axi_rvalid          = st.rvalid;
  assign scan_rsp              = st.scan;
  assign glyph_rsp             = st.glyph;
  assign attr_out              = st.attr;
  assign combine_mode          = st.combine;
  assign glyph_external        = st.glyph_ext;
  assign graphic_suppress      = st.combine[3];  // attribute bit of the one-hot flop [R19]
  assign cursor_col            = st.cur_col;
  assign cursor_row            = st.cur_row;
  assign cursor_lower_half     = st.cur_lower;
  assign access_ptr            = st.adp;
  assign hardware_column_count = st.hw_cols;

  default clocking lpc_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // cursor takes the stacked bytes on its command
  property p_cursor_load;
    exec_cmd && (cmd == LPC_CMD_CURSOR) |=>
      (cursor_col == $past(st.d1[6:0])) && (cursor_row == $past(st.d2[4:0]));
  endproperty
  a_cursor_load: assert property (p_cursor_load) else $error("cursor not loaded");  // [R01]

  // nothing else moves the cursor
  property p_cursor_hold;
    !(exec_cmd && (cmd == LPC_CMD_CURSOR)) |=> $stable(cursor_col) && $stable(cursor_row);
  endproperty
  a_cursor_hold: assert property (p_cursor_hold) else $error("cursor moved");  // [R02]

  // offset keeps five low bits of the first byte
  property p_offset_load;
    exec_cmd && (cmd == LPC_CMD_OFFSET) |=> st.offset == $past(st.d1[4:0]);
  endproperty
  a_offset_load: assert property (p_offset_load) else $error("offset wrong");  // [R25]

  // access pointer low then high
  property p_adp_load;
    exec_cmd && (cmd == LPC_CMD_ADDR_PTR) |=> access_ptr == {$past(st.d2), $past(st.d1)};
  endproperty
  a_adp_load: assert property (p_adp_load) else $error("pointer wrong");  // [R09]

  // parameter stack shifts on each data write
  property p_stack_shift;
    push_data |=> (st.d1 == $past(st.d2)) && (st.d2 == $past(st.wdata[7:0]));
  endproperty
  a_stack_shift: assert property (p_stack_shift) else $error("stack wrong");  // [R23]

  // glyph address concatenation
  property p_glyph_addr;
    glyph_req.valid |=> glyph_rsp.valid &&
      (glyph_rsp.addr == {$past(st.offset), $past(glyph_req.code), $past(glyph_req.line)});
  endproperty
  a_glyph_addr: assert property (p_glyph_addr) else $error("glyph address wrong");  // [R06]

  // rom only for low codes in internal mode
  property p_glyph_src;
    glyph_req.valid |=> glyph_rsp.from_rom ==
      (!$past(st.glyph_ext) && !$past(glyph_req.code[7]));
  endproperty
  a_glyph_src: assert property (p_glyph_src) else $error("glyph source wrong");  // [R07]

  // mode stays without a mode command
  property p_mode_hold;
    !(exec_cmd && (cmd[7:4] == LPC_CMD_MODE_HI)) |=>
      $stable(combine_mode) && $stable(glyph_external);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed");  // [R18]

  // text scan address formula
  property p_text_scan;
    scan_req.valid && !scan_req.graphic |=> scan_rsp.addr ==
      16'($past(st.text_base) + $past(scan_req.row) * $past(st.text_pitch)
          + $past(scan_req.col));
  endproperty
  a_text_scan: assert property (p_text_scan) else $error("text address wrong");  // [R11]

  // reverse with d3 adds blink and nothing else
  property p_attr_rev;
    attr_byte[3:0] == 4'hD |=> attr_out.reverse && attr_out.blink &&
      !attr_out.bold && !attr_out.inhibit;
  endproperty
  a_attr_rev: assert property (p_attr_rev) else $error("attribute decode wrong");  // [R21]

endmodule

`default_nettype wire

//--- sim/lpc_scan_model.sv
// display scan side model: issues scan, glyph and attribute requests
`timescale 1ns/1ps
`default_nettype none
module lpc_scan_model
(
  input  wire logic                    mclk,
  input  wire logic                    go,
  input  wire logic [1:0]              kind,
  input  wire logic [7:0]              a,
  input  wire logic [7:0]              b,
  output var  lpc_pkg::lpc_scan_req_t  sreq,
  output var  lpc_pkg::lpc_glyph_req_t greq,
  output var  logic                    av,
  output var  logic [7:0]              ab
);
  import lpc_pkg::*;
  // kind 0 text, 1 graphic, 2 glyph, 3 attribute; one cycle each
  always @(posedge mclk)
  begin
    sreq <= {go && !kind[1], kind[0], a, b[6:0]};
    greq <= {go && kind == 2'd2, a, b[2:0]};
    av   <= go && kind == 2'd3;
    // idle byte flips so a stale value is never trusted
    ab   <= go ? b : ~b;
  end
endmodule
`default_nettype wire

//--- sim/test_lcd_pointer_and_mode_commands.sv
// self-checking bench of the pointer and mode decoder
`timescale 1ns/1ps
`default_nettype none
module test_lcd_pointer_and_mode_commands;
  import lpc_pkg::*;
  logic           mclk, rst_n, awv, wv, bready, arv, rready, go, sa, sb, sd;
  logic [1:0]     kind, bresp, rresp;
  logic [3:0]     strb;
  logic [7:0]     awaddr, araddr, pa, pb, ab, hwc, mc [5], at [5];
  logic [31:0]    wdata, rdata;
  logic [4:0]     me [5], ae [5], crow;
  logic [6:0]     ccol;
  logic [15:0]    aptr;
  logic           awready, wready, bvalid, arready, rvalid, av, gx, gs, lh;
  lpc_scan_req_t  sreq;
  lpc_scan_rsp_t  srsp;
  lpc_glyph_req_t greq;
  lpc_glyph_rsp_t grsp;
  lpc_attr_t      aout;
  lpc_combine_t   cmb;
  int             err_total, checks, cyc;
  assign mc = '{8'h80, 8'h81, 8'h83, 8'h84, 8'h88};
  assign me = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h11};
  assign at = '{8'hF5, 8'h0D, 8'h07, 8'h03, 8'h02};
  assign ae = '{5'h18, 5'h19, 5'h12, 5'h14, 5'h10};
  lpc_core u_dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .column_strap_a(sa), .column_strap_b(sb),
    .dual_scan_strap(sd), .scan_req(sreq), .scan_rsp(srsp),
    .glyph_req(greq), .glyph_rsp(grsp), .attr_valid(av), .attr_byte(ab),
    .attr_out(aout), .combine_mode(cmb), .glyph_external(gx),
    .graphic_suppress(gs), .cursor_col(ccol), .cursor_row(crow),
    .cursor_lower_half(lh), .access_ptr(aptr), .hardware_column_count(hwc));
  lpc_scan_model u_scan (.mclk(mclk), .go(go), .kind(kind), .a(pa), .b(pb),
    .sreq(sreq), .greq(greq), .av(av), .ab(ab));
  task automatic end_sim;
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // write: address and data offered together, response checked
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata  <= {24'h00_0000, d};
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    do @(negedge mclk); while (!(awready === 1'b1 && wready === 1'b1));
    @(posedge mclk);
    awv <= 1'b0;
    wv  <= 1'b0;
    do @(negedge mclk); while (!(bvalid === 1'b1));
    chk("bresp", LPC_RESP_OKAY, bresp);
    @(posedge mclk);
    bready <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    do @(negedge mclk); while (!(arready === 1'b1));
    @(posedge mclk);
    arv <= 1'b0;
    do @(negedge mclk); while (!(rvalid === 1'b1));
    chk("rdata", e, rdata);
    chk("rresp", r, rresp);
    @(posedge mclk);
    rready <= 1'b0;
    @(negedge mclk);
  endtask
  // parameters first, then the command that consumes them
  task automatic cmd(input logic [7:0] c, input logic [7:0] d1, input logic [7:0] d2);
    wr(LPC_OFS_DATA, d1);
    wr(LPC_OFS_DATA, d2);
    wr(LPC_OFS_CMD, c);
  endtask
  // one request through the model; answer settles before the negedge
  task automatic req(input logic [1:0] k, input logic [7:0] x, input logic [7:0] y);
    @(posedge mclk);
    go   <= 1'b1;
    kind <= k;
    pa   <= x;
    pb   <= y;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // hang guard, far beyond the few hundred cycles the run needs
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    {rst_n, awv, wv, bready, arv, rready, go, kind, awaddr, araddr} = '0;
    {pa, pb, wdata, err_total, checks} = '0;
    {sa, sb, sd} = 3'b111;
    strb = 4'hF;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(LPC_OFS_STATUS, 32'h0000_0120, LPC_RESP_OKAY);
    chk("columns", 32'h0000_0020, {24'h0, hwc});
    rd(LPC_OFS_MODE, 32'h0000_0001, LPC_RESP_OKAY);
    cmd(LPC_CMD_CURSOR, 8'hD3, 8'hF5);
    rd(LPC_OFS_CURSOR, 32'h0000_1553, LPC_RESP_OKAY);
    chk("lower", 32'h1, lh);
    wr(LPC_OFS_DATA, 8'hAA);
    cmd(LPC_CMD_ADDR_PTR, 8'h34, 8'h12);
    chk("aptr", 32'h0000_1234, aptr);
    rd(LPC_OFS_CURSOR, 32'h0000_1553, LPC_RESP_OKAY);
    chk("cursor pins", 32'h0000_1553, {19'h0, crow, 1'b0, ccol});
    cmd(LPC_CMD_OFFSET, 8'hFF, 8'h00);
    req(2'd2, 8'h41, 8'h05);
    chk("glyph", {2'b11, 5'h1F, 8'h41, 3'h5}, grsp);
    req(2'd2, 8'h80, 8'h00);
    chk("glyph", {2'b10, 5'h1F, 8'h80, 3'h0}, grsp);
    for (int i = 0; i < 5; i++)
    begin
      wr(LPC_OFS_CMD, mc[i]);
      rd(LPC_OFS_MODE, {27'h0, me[i]}, LPC_RESP_OKAY);
      chk("mode pins", {27'h0, me[i]}, {27'h0, gx, cmb});
    end
    req(2'd2, 8'h41, 8'h05);
    chk("glyph", {2'b10, 5'h1F, 8'h41, 3'h5}, grsp);
    cmd(LPC_CMD_TEXT_BASE, 8'h34, 8'h12);
    cmd(LPC_CMD_TEXT_PITCH, 8'h20, 8'h00);
    rd(LPC_OFS_MODE, 32'h0000_0011, LPC_RESP_OKAY);
    req(2'd0, 8'h02, 8'h03);
    chk("scan", {2'b10, 16'h1277}, srsp);
    cmd(LPC_CMD_GFX_BASE, 8'h00, 8'h02);
    cmd(LPC_CMD_GFX_PITCH, 8'h20, 8'h00);
    req(2'd1, 8'h01, 8'h1F);
    chk("scan", {2'b10, 16'h023F}, srsp);
    req(2'd1, 8'h02, 8'h00);
    chk("scan", {2'b10, 16'h0240}, srsp);
    wr(LPC_OFS_CMD, 8'h9C);
    wr(LPC_OFS_CMD, 8'h84);
    chk("suppress", 32'h1, gs);
    req(2'd1, 8'h00, 8'h00);
    chk("scan", {2'b11, 16'h0200}, srsp);
    for (int i = 0; i < 5; i++)
    begin
      req(2'd3, 8'h00, at[i]);
      chk("attr", {27'h0, ae[i]}, aout);
    end
    // lane 0 disabled: the mode command must be ignored
    @(posedge mclk);
    strb <= 4'hE;
    wr(LPC_OFS_CMD, 8'h80);
    @(posedge mclk);
    strb <= 4'hF;
    rd(LPC_OFS_MODE, 32'h0000_0008, LPC_RESP_OKAY);
    // unlisted combine code falls back to or
    wr(LPC_OFS_CMD, 8'h86);
    rd(LPC_OFS_MODE, 32'h0000_0001, LPC_RESP_OKAY);
    chk("suppress", 32'h0, gs);
    // single scan, other column strapping
    @(posedge mclk);
    {sa, sb, sd} <= 3'b000;
    repeat (4) @(posedge mclk);
    rd(LPC_OFS_STATUS, 32'h0000_0028, LPC_RESP_OKAY);
    chk("columns", 32'h0000_0028, {24'h0, hwc});
    chk("lower", 32'h0, lh);
    rd(8'h2C, 32'h0000_0000, LPC_RESP_SLVERR);
    end_sim();
  end
endmodule
`default_nettype wire
